// file: design/dsis_defs.svh
`ifndef DSIS_DEFS_SVH
`define DSIS_DEFS_SVH

`define DSIS_ADDR_W          7
`define DSIS_NREG            12
`define DSIS_CNT_W           24

`define DSIS_OFS_SPI_CFG     7'h00
`define DSIS_OFS_RX_CTRL     7'h10
`define DSIS_OFS_FINE_DELAY  7'h13
`define DSIS_OFS_CLK_DIV     7'h14
`define DSIS_OFS_RX_STATUS   7'h21
`define DSIS_OFS_BIAS_A      7'h22
`define DSIS_OFS_BIAS_B      7'h23
`define DSIS_OFS_LOOP_CFG_A  7'h24
`define DSIS_OFS_LOOP_CFG_B  7'h25
`define DSIS_OFS_LOOP_CTRL   7'h26
`define DSIS_OFS_LOOP_CFG_C  7'h27
`define DSIS_OFS_LOOP_CFG_D  7'h28
`define DSIS_OFS_LOOP_CFG_E  7'h29
`define DSIS_OFS_LOOP_STATUS 7'h2a

`define DSIS_IDX_SPI_CFG     4'h0
`define DSIS_IDX_RX_CTRL     4'h1
`define DSIS_IDX_FINE_DELAY  4'h2
`define DSIS_IDX_CLK_DIV     4'h3
`define DSIS_IDX_BIAS_A      4'h4
`define DSIS_IDX_BIAS_B      4'h5
`define DSIS_IDX_LOOP_CFG_A  4'h6
`define DSIS_IDX_LOOP_CFG_B  4'h7
`define DSIS_IDX_LOOP_CTRL   4'h8
`define DSIS_IDX_LOOP_CFG_C  4'h9
`define DSIS_IDX_LOOP_CFG_D  4'ha
`define DSIS_IDX_LOOP_CFG_E  4'hb

`define DSIS_BIT_LSB_FIRST   6
`define DSIS_BIT_LSB_FIRST_M 1
`define DSIS_BIT_SOFT_RST    5
`define DSIS_BIT_SOFT_RST_M  2
`define DSIS_BIT_CTRL_SEARCH 0
`define DSIS_BIT_CTRL_ENABLE 1
`define DSIS_BIT_STAT_LOCKED 0
`define DSIS_BIT_STAT_TRACK  3
`define DSIS_BIT_READ        7
`define DSIS_FINE_SKEW_HI    3
`define DSIS_CLK_DIV_HI      7
`define DSIS_CLK_DIV_LO      6

`define DSIS_RST_REG         8'h00
`define DSIS_INSTR_LAST      5'd7
`define DSIS_FRAME_LAST      5'd15
`define DSIS_FRAME_BITS      5'd16
`define DSIS_LOCK_CYCLES     1024

`endif

// file: design/dsis_pkg.sv
package dsis_pkg;
`include "dsis_defs.svh"

    typedef logic [`DSIS_ADDR_W-1:0] dsis_addr_t;
    typedef logic [7:0]              dsis_byte_t;

    typedef struct packed
    {
        dsis_addr_t addr;
        dsis_byte_t data;
    } dsis_wr_t;

    typedef struct packed
    {
        logic       hit;
        logic [3:0] idx;
    } dsis_dec_t;

    typedef enum logic [1:0]
    {
        DSIS_LK_IDLE   = 2'b00,
        DSIS_LK_SEARCH = 2'b01,
        DSIS_LK_TRACK  = 2'b10
    } dsis_lock_st_t;

    typedef struct packed
    {
        dsis_lock_st_t          st;
        logic [`DSIS_CNT_W-1:0] cnt;
    } dsis_lock_state_t;

    typedef struct packed
    {
        logic [4:0] bits;
        logic [7:0] shift;
        logic       rd;
        dsis_addr_t addr;
        dsis_byte_t tx;
        logic       sdo;
        logic       oe;
    } dsis_frame_t;

    typedef struct packed
    {
        logic [`DSIS_NREG-1:0][7:0] regs;
        dsis_wr_t                   hold;
        logic                       wr_tgl;
        logic [1:0]                 rst_sync;
        logic [2:0]                 sta_s1;
        logic [2:0]                 sta_s2;
    } dsis_link_t;

    typedef struct packed
    {
        logic       wr_s1;
        logic       wr_s2;
        logic       wr_prev;
        logic       ack_s1;
        logic       ack_s2;
        logic       rst_pend;
        dsis_byte_t rx_ctrl;
        dsis_byte_t loop_ctrl;
        logic [3:0] fine_skew;
        logic [1:0] clk_div;
        logic       odc;
        logic       irq;
    } dsis_sys_t;

    function automatic dsis_dec_t dsis_decode(input dsis_addr_t a);
        dsis_dec_t d;
        d.hit = 1'b1;
        d.idx = 4'h0;
        case (a)
            `DSIS_OFS_SPI_CFG:    d.idx = `DSIS_IDX_SPI_CFG;
            `DSIS_OFS_RX_CTRL:    d.idx = `DSIS_IDX_RX_CTRL;
            `DSIS_OFS_FINE_DELAY: d.idx = `DSIS_IDX_FINE_DELAY;
            `DSIS_OFS_CLK_DIV:    d.idx = `DSIS_IDX_CLK_DIV;
            `DSIS_OFS_BIAS_A:     d.idx = `DSIS_IDX_BIAS_A;
            `DSIS_OFS_BIAS_B:     d.idx = `DSIS_IDX_BIAS_B;
            `DSIS_OFS_LOOP_CFG_A: d.idx = `DSIS_IDX_LOOP_CFG_A;
            `DSIS_OFS_LOOP_CFG_B: d.idx = `DSIS_IDX_LOOP_CFG_B;
            `DSIS_OFS_LOOP_CTRL:  d.idx = `DSIS_IDX_LOOP_CTRL;
            `DSIS_OFS_LOOP_CFG_C: d.idx = `DSIS_IDX_LOOP_CFG_C;
            `DSIS_OFS_LOOP_CFG_D: d.idx = `DSIS_IDX_LOOP_CFG_D;
            `DSIS_OFS_LOOP_CFG_E: d.idx = `DSIS_IDX_LOOP_CFG_E;
            default:              d.hit = 1'b0;
        endcase
        return d;
    endfunction

    function automatic dsis_byte_t dsis_rev(input dsis_byte_t b);
        dsis_byte_t r;
        r = '0;
        for (int i = 0; i < 8; i++)
        begin
            r[i] = b[7-i];
        end
        return r;
    endfunction

    function automatic logic dsis_soft_rst(input dsis_byte_t b);
        return b[`DSIS_BIT_SOFT_RST] | b[`DSIS_BIT_SOFT_RST_M];
    endfunction

endpackage

// file: design/dsis_lock_ctrl.sv
`timescale 1ns/10ps
`include "dsis_defs.svh"

module dsis_lock_ctrl #(
    parameter int LOCK_CYCLES = `DSIS_LOCK_CYCLES
) (
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    input  wire logic enable_i,
    input  wire logic search_i,
    input  wire logic prereq_i,
    output logic      locked_o,
    output logic      tracking_o
);
    import dsis_pkg::*;

    localparam logic [`DSIS_CNT_W-1:0] LAST = `DSIS_CNT_W'(LOCK_CYCLES - 1);

    dsis_lock_state_t s_r;
    dsis_lock_state_t s_nxt;
    logic             run;

    always_comb
    begin
        s_nxt = s_r;
        run   = enable_i & search_i & prereq_i;
        case (s_r.st)
            DSIS_LK_IDLE:
            begin
                s_nxt.cnt = '0;
                if (run)
                    s_nxt.st = DSIS_LK_SEARCH;
            end
            DSIS_LK_SEARCH:
            begin
                if (!run)
                    s_nxt.st = DSIS_LK_IDLE;
                else if (s_r.cnt == LAST)
                    s_nxt.st = DSIS_LK_TRACK;
                else
                    s_nxt.cnt = s_r.cnt + 1'b1;
            end
            DSIS_LK_TRACK:
            begin
                // losing the prerequisite drops lock: search restarts by itself once enable, search and prerequisite are all high again
                if (!run)
                    s_nxt.st = DSIS_LK_IDLE;
            end
            default:
                s_nxt.st = DSIS_LK_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            s_r <= '{st: DSIS_LK_IDLE, cnt: '0};
        else
            s_r <= s_nxt;
    end

    assign locked_o   = (s_r.st == DSIS_LK_TRACK);
    assign tracking_o = (s_r.st == DSIS_LK_TRACK);

endmodule

// file: design/dsis_spi_link.sv
`timescale 1ns/10ps
`include "dsis_defs.svh"

module dsis_spi_link (
    input  wire logic       spi_clk_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_sdi_i,
    output logic            spi_sdo_o,
    output logic            spi_sdo_oe_o,
    input  wire logic       rst_req_i,
    output logic            rst_ack_o,
    input  wire logic [2:0] status_i,
    output dsis_pkg::dsis_wr_t wr_o,
    output logic            wr_tgl_o
);
    import dsis_pkg::*;

    dsis_frame_t f_r;
    dsis_frame_t f_nxt;
    dsis_link_t  l_r;
    dsis_link_t  l_nxt;
    logic        lsb;
    dsis_byte_t  sb;
    dsis_byte_t  instr;
    dsis_byte_t  wdata;
    dsis_byte_t  rb;
    dsis_byte_t  txb;
    dsis_dec_t   dec;

    function automatic dsis_byte_t readback(input dsis_addr_t a, input dsis_link_t l);
        dsis_dec_t  d;
        dsis_byte_t v;
        d = dsis_decode(a);
        v = 8'h00;
        if (d.hit)
            v = l.regs[d.idx];
        else if (a == `DSIS_OFS_RX_STATUS)
        begin
            v[`DSIS_BIT_STAT_LOCKED] = l.sta_s2[1];
            v[`DSIS_BIT_STAT_TRACK]  = l.sta_s2[2];
        end
        else if (a == `DSIS_OFS_LOOP_STATUS)
            v[`DSIS_BIT_STAT_LOCKED] = l.sta_s2[0];
        return v;
    endfunction

    always_comb
    begin
        f_nxt = f_r;
        l_nxt = l_r;
        l_nxt.rst_sync = {l_r.rst_sync[0], rst_req_i};
        l_nxt.sta_s1   = status_i;
        l_nxt.sta_s2   = l_r.sta_s1;
        lsb   = l_r.regs[`DSIS_IDX_SPI_CFG][`DSIS_BIT_LSB_FIRST]
              | l_r.regs[`DSIS_IDX_SPI_CFG][`DSIS_BIT_LSB_FIRST_M];
        sb    = {f_r.shift[6:0], spi_sdi_i};
        instr = lsb ? dsis_rev(sb) : sb;
        wdata = lsb ? dsis_rev(sb) : sb;
        dec   = dsis_decode(f_r.addr);
        rb    = readback(instr[`DSIS_ADDR_W-1:0], l_r);
        txb   = lsb ? dsis_rev(rb) : rb;
        if (l_r.rst_sync[1])
        begin
            // the write handshake powers up unknown: park it, or no write ever reaches sys
            l_nxt.hold   = '0;
            l_nxt.wr_tgl = 1'b0;
            for (int i = 0; i < `DSIS_NREG; i++)
            begin
                l_nxt.regs[i] = `DSIS_RST_REG;
            end
        end
        if (f_r.bits < `DSIS_FRAME_BITS)
        begin
            f_nxt.bits  = f_r.bits + 1'b1;
            f_nxt.shift = sb;
            if (f_r.bits == `DSIS_INSTR_LAST)
            begin
                f_nxt.rd   = instr[`DSIS_BIT_READ];
                f_nxt.addr = instr[`DSIS_ADDR_W-1:0];
                f_nxt.tx   = txb;
                f_nxt.sdo  = txb[7];
                f_nxt.oe   = instr[`DSIS_BIT_READ];
            end
            else if (f_r.bits > `DSIS_INSTR_LAST && f_r.bits < `DSIS_FRAME_LAST)
            begin
                f_nxt.tx  = {f_r.tx[6:0], 1'b0};
                f_nxt.sdo = f_r.tx[6];
            end
            else if (f_r.bits == `DSIS_FRAME_LAST)
            begin
                f_nxt.oe  = 1'b0;
                f_nxt.sdo = 1'b0;
                if (!f_r.rd)
                begin
                    l_nxt.hold   = '{addr: f_r.addr, data: wdata};
                    l_nxt.wr_tgl = ~l_r.wr_tgl;
                    if (dec.hit && dec.idx == `DSIS_IDX_SPI_CFG && dsis_soft_rst(wdata))
                    begin
                        // reset bit itself reads back until the host clears it
                        for (int i = 0; i < `DSIS_NREG; i++)
                        begin
                            l_nxt.regs[i] = `DSIS_RST_REG;
                        end
                        l_nxt.regs[`DSIS_IDX_SPI_CFG] = wdata;
                    end
                    else if (dec.hit)
                        l_nxt.regs[dec.idx] = wdata;
                end
            end
        end
    end

    // frame counters end with chip select, since the host's clock stops between frames
    always_ff @(posedge spi_clk_i or posedge spi_cs_n_i)
    begin
        if (spi_cs_n_i)
            f_r <= '0;
        else
            f_r <= f_nxt;
    end

    always_ff @(posedge spi_clk_i)
    begin
        l_r <= l_nxt;
    end

    assign spi_sdo_o    = f_r.sdo;
    assign spi_sdo_oe_o = f_r.oe;
    assign rst_ack_o    = l_r.rst_sync[1];
    assign wr_o         = l_r.hold;
    assign wr_tgl_o     = l_r.wr_tgl;

endmodule

// file: design/dsis_top.sv
// Contract
// - Power-on or hardware reset returns every register to its default state.
// - Output data clock comes from the phase-tracking controller; invalid before lock.
// - Controller status is visible on an interrupt output and by status polling.
// - Writing 0x20 to 0x00 resets all serial registers; 0x00 clears reset bit.
`timescale 1ns/10ps
`include "dsis_defs.svh"

module dsis_top #(
    parameter int LOCK_CYCLES = `DSIS_LOCK_CYCLES
) (
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    input  wire logic spi_clk_i,
    input  wire logic spi_cs_n_i,
    input  wire logic spi_sdi_i,
    output logic      spi_sdo_o,
    output logic      spi_sdo_oe_o,
    output logic      output_data_clock_o,
    output logic      controller_irq_o,
    output logic [3:0] fine_input_delay_skew_o,
    output logic [1:0] clock_divider_phase_o
);
    import dsis_pkg::*;

    localparam dsis_sys_t SYS_RST = '{
        wr_s1:     1'b0,
        wr_s2:     1'b0,
        wr_prev:   1'b0,
        ack_s1:    1'b0,
        ack_s2:    1'b0,
        rst_pend:  1'b1,
        rx_ctrl:   `DSIS_RST_REG,
        loop_ctrl: `DSIS_RST_REG,
        fine_skew: 4'h0,
        clk_div:   2'h0,
        odc:       1'b0,
        irq:       1'b0
    };

    dsis_sys_t s_r;
    dsis_sys_t s_nxt;
    dsis_wr_t  wr;
    logic      wr_tgl;
    logic      rst_ack;
    logic      ph_locked;
    logic      ph_tracking;
    logic      rx_locked;
    logic      rx_tracking;
    logic      wr_ev;

    dsis_spi_link u_link (
        .spi_clk_i    (spi_clk_i),
        .spi_cs_n_i   (spi_cs_n_i),
        .spi_sdi_i    (spi_sdi_i),
        .spi_sdo_o    (spi_sdo_o),
        .spi_sdo_oe_o (spi_sdo_oe_o),
        .rst_req_i    (s_r.rst_pend),
        .rst_ack_o    (rst_ack),
        .status_i     ({rx_tracking, rx_locked, ph_locked}),
        .wr_o         (wr),
        .wr_tgl_o     (wr_tgl)
    );

    dsis_lock_ctrl #(
        .LOCK_CYCLES (LOCK_CYCLES)
    ) u_phase_loop (
        .sys_clk_i  (sys_clk_i),
        .resetn_i   (resetn_i),
        .enable_i   (s_r.loop_ctrl[`DSIS_BIT_CTRL_ENABLE]),
        .search_i   (s_r.loop_ctrl[`DSIS_BIT_CTRL_SEARCH]),
        .prereq_i   (1'b1),
        .locked_o   (ph_locked),
        .tracking_o (ph_tracking)
    );

    // receiver cannot search without the clock the phase loop produces
    dsis_lock_ctrl #(
        .LOCK_CYCLES (LOCK_CYCLES)
    ) u_rx_loop (
        .sys_clk_i  (sys_clk_i),
        .resetn_i   (resetn_i),
        .enable_i   (s_r.rx_ctrl[`DSIS_BIT_CTRL_ENABLE]),
        .search_i   (s_r.rx_ctrl[`DSIS_BIT_CTRL_SEARCH]),
        .prereq_i   (ph_tracking),
        .locked_o   (rx_locked),
        .tracking_o (rx_tracking)
    );

    always_comb
    begin
        s_nxt         = s_r;
        s_nxt.wr_s1   = wr_tgl;
        s_nxt.wr_s2   = s_r.wr_s1;
        s_nxt.wr_prev = s_r.wr_s2;
        s_nxt.ack_s1  = rst_ack;
        s_nxt.ack_s2  = s_r.ack_s1;
        wr_ev         = s_r.wr_s2 ^ s_r.wr_prev;
        // hold the request until the link domain has cleared its copy
        if (s_r.ack_s2)
            s_nxt.rst_pend = 1'b0;
        if (wr_ev)
        begin
            case (wr.addr)
                `DSIS_OFS_SPI_CFG:
                begin
                    if (dsis_soft_rst(wr.data))
                    begin
                        s_nxt.rx_ctrl   = `DSIS_RST_REG;
                        s_nxt.loop_ctrl = `DSIS_RST_REG;
                        s_nxt.fine_skew = 4'h0;
                        s_nxt.clk_div   = 2'h0;
                    end
                end
                `DSIS_OFS_RX_CTRL:    s_nxt.rx_ctrl   = wr.data;
                `DSIS_OFS_LOOP_CTRL:  s_nxt.loop_ctrl = wr.data;
                `DSIS_OFS_FINE_DELAY: s_nxt.fine_skew = wr.data[`DSIS_FINE_SKEW_HI:0];
                `DSIS_OFS_CLK_DIV:
                    s_nxt.clk_div = wr.data[`DSIS_CLK_DIV_HI:`DSIS_CLK_DIV_LO];
                default:
                    s_nxt.rx_ctrl = s_r.rx_ctrl;
            endcase
        end
        // divided stand-in for the loop's clock; parked low while the loop is not locked
        s_nxt.odc = ph_locked ? ~s_r.odc : 1'b0;
        s_nxt.irq = (s_r.rx_ctrl[`DSIS_BIT_CTRL_ENABLE] & rx_locked)
                  | (s_r.loop_ctrl[`DSIS_BIT_CTRL_ENABLE] & ph_locked);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            s_r <= SYS_RST;
        else
            s_r <= s_nxt;
    end

    assign output_data_clock_o     = s_r.odc;
    assign controller_irq_o        = s_r.irq;
    assign fine_input_delay_skew_o = s_r.fine_skew;
    assign clock_divider_phase_o   = s_r.clk_div;

endmodule

// file: verif/dsis_checker.sv
`timescale 1ns/10ps

module dsis_checker #(
    parameter int LOCK_CYCLES = 16
) (
    input wire logic       sys_clk_i,
    input wire logic       resetn_i,
    input wire logic       spi_clk_i,
    input wire logic       spi_cs_n_i,
    input wire logic       spi_sdi_i,
    input wire logic       spi_sdo_o,
    input wire logic       spi_sdo_oe_o,
    input wire logic       output_data_clock_o,
    input wire logic       controller_irq_o,
    input wire logic [3:0] fine_input_delay_skew_o,
    input wire logic [1:0] clock_divider_phase_o
);
    logic [4:0] bit_cnt_r;
    logic       first_bit_r;
    logic       last_bit_r;
    logic [3:0] idle_cnt_r;
    int         since_rst_r;

    // frame position; chip select high clears it like the device does
    always_ff @(posedge spi_clk_i or posedge spi_cs_n_i)
    begin
        if (spi_cs_n_i)
            bit_cnt_r <= 5'h00;
        else
        begin
            if (bit_cnt_r != 5'h1f)
                bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r == 5'h00)
                first_bit_r <= spi_sdi_i;
            if (bit_cnt_r == 5'h07)
                last_bit_r <= spi_sdi_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i || !spi_cs_n_i)
            idle_cnt_r <= 4'h0;
        else if (idle_cnt_r != 4'hf)
            idle_cnt_r <= idle_cnt_r + 4'h1;
        if (!resetn_i)
            since_rst_r <= 0;
        else if (since_rst_r < LOCK_CYCLES)
            since_rst_r <= since_rst_r + 1;
    end

    // odd-address read looks the same in either bit order: first and eighth bits both set
    sequence s_read_instr;
        bit_cnt_r == 5'h08 && first_bit_r && last_bit_r;
    endsequence
    sequence s_write_instr;
        bit_cnt_r == 5'h08 && !first_bit_r && !last_bit_r;
    endsequence
    sequence s_irq_held;
        controller_irq_o [*3];
    endsequence

    AST_RESET_CLEARS: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> {output_data_clock_o, controller_irq_o, fine_input_delay_skew_o,
        clock_divider_phase_o} == 8'h00) else $error("outputs not cleared by reset");
    AST_ODC_TOGGLES: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        output_data_clock_o |=> !output_data_clock_o) else $error("data clock stuck high");
    AST_ODC_WAITS: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        output_data_clock_o |-> since_rst_r >= LOCK_CYCLES) else $error("data clock too early");
    AST_IRQ_CLOCK: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        s_irq_held |-> output_data_clock_o != $past(output_data_clock_o)
        || $past(output_data_clock_o) != $past(output_data_clock_o, 2))
        else $error("status high without running loop");
    AST_OE_IDLE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        spi_cs_n_i |-> !spi_sdo_oe_o) else $error("data out driven while deselected");
    AST_OE_INSTR: assert property (@(posedge spi_clk_i) disable iff (spi_cs_n_i)
        bit_cnt_r < 5'h08 |-> !spi_sdo_oe_o) else $error("data out driven in instruction");
    AST_OE_READ: assert property (@(posedge spi_clk_i) disable iff (spi_cs_n_i)
        s_read_instr |-> spi_sdo_oe_o) else $error("read data not driven");
    AST_OE_WRITE: assert property (@(posedge spi_clk_i) disable iff (spi_cs_n_i)
        s_write_instr |-> !spi_sdo_oe_o) else $error("data out driven on write");
    AST_FIELDS_QUIET: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        idle_cnt_r >= 4'h8 |-> $stable(fine_input_delay_skew_o) && $stable(clock_divider_phase_o))
        else $error("field output moved without a frame");
endmodule

// file: verif/dsis_host_model.sv
`timescale 1ns/10ps

module dsis_host_model (
    output logic      spi_clk_o,
    output logic      spi_cs_n_o,
    output logic      spi_sdi_o,
    input  wire logic spi_sdo_i,
    input  wire logic spi_sdo_oe_i
);
    logic lsb_first;

    initial
    begin
        spi_clk_o = 1'b0;
        spi_cs_n_o = 1'b0;
        spi_sdi_o = 1'b0;
        lsb_first = 1'b0;
        // a real rising select clears the frame counters before the first frame
        #1;
        spi_cs_n_o = 1'b1;
    end

    // clock parked low between frames; data changes just after the falling edge
    task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdat,
                        output logic [7:0] rdat);
        logic [1:0][7:0] frm;
        int              p;
        frm = {rd, addr, wdat};
        rdat = 8'h00;
        spi_cs_n_o = 1'b0;
        for (int k = 0; k < 16; k++)
        begin
            p = lsb_first ? k % 8 : 7 - k % 8;
            spi_sdi_o = frm[1 - k / 8][p];
            #7.5;
            if (k >= 8)
                rdat[p] = spi_sdo_oe_i ? spi_sdo_i : 1'b1; // undriven line reads high
            spi_clk_o = 1'b1;
            #7.5;
            spi_clk_o = 1'b0;
        end
        spi_sdi_o = ~spi_sdi_o;
        #7.5;
        spi_cs_n_o = 1'b1;
        #15;
    endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module tb_top;
    import dsis_pkg::*;
    localparam int LOCK_CYCLES = 16;
    localparam logic [6:0] RW_TAB [9] = '{7'h22, 7'h23, 7'h24, 7'h25, 7'h27, 7'h28, 7'h29,
                                          7'h13, 7'h14};
    logic       sys_clk_i;
    logic       resetn_i;
    logic       spi_clk;
    logic       spi_cs_n;
    logic       spi_sdi;
    logic       spi_sdo;
    logic       spi_sdo_oe;
    logic       odc;
    logic       irq;
    logic [3:0] skew;
    logic [1:0] div;
    int         error_cnt;
    int         tests_run;

    dsis_top #(.LOCK_CYCLES(LOCK_CYCLES)) dsis_top_i (.sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i), .spi_clk_i(spi_clk), .spi_cs_n_i(spi_cs_n), .spi_sdi_i(spi_sdi),
        .spi_sdo_o(spi_sdo), .spi_sdo_oe_o(spi_sdo_oe), .output_data_clock_o(odc),
        .controller_irq_o(irq), .fine_input_delay_skew_o(skew), .clock_divider_phase_o(div));
    dsis_host_model dsis_host_model_i (.spi_clk_o(spi_clk), .spi_cs_n_o(spi_cs_n),
        .spi_sdi_o(spi_sdi), .spi_sdo_i(spi_sdo), .spi_sdo_oe_i(spi_sdo_oe));

    initial
    begin
        sys_clk_i = 1'b0;
    end
    always #10 sys_clk_i = ~sys_clk_i;

    function automatic logic [3:0] exp_skew(input logic [7:0] d);
        return d[3:0];
    endfunction
    function automatic logic [1:0] exp_div(input logic [7:0] d);
        return d[7:6];
    endfunction

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // spacing leaves the sys side time to take each write
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        dsis_host_model_i.xfer(1'b0, a, d, dummy);
        repeat (8) @(posedge sys_clk_i);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] got;
        dsis_host_model_i.xfer(1'b1, a, 8'h00, got);
        `CHK(nm, exp, got)
    endtask
    task automatic lock_try(input logic [6:0] ca, input logic [6:0] sa, input logic [7:0] ok);
        logic [7:0] got;
        for (int n = 0; n < 3; n++)
        begin
            wr(ca, 8'h00);
            wr(ca, 8'h02);
            wr(ca, 8'h03);
            repeat (LOCK_CYCLES + 8) @(posedge sys_clk_i);
            dsis_host_model_i.xfer(1'b1, sa, 8'h00, got);
            if (got === ok)
                break;
        end
        `CHK("lock status", ok, got)
    endtask

    initial
    begin
        repeat (60000) @(posedge sys_clk_i);
        error_cnt++;
        final_report();
    end

    initial
    begin
        logic [7:0] d;
        error_cnt = 0;
        tests_run = 0;
        resetn_i = 1'b0;
        d = 8'($urandom(48785));
        repeat (20) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        `CHK("outputs in reset", 8'h00, {skew, div, odc, irq})
        repeat (4) @(posedge sys_clk_i);
        // single device: the alignment controller is never enabled
        wr(7'h00, 8'h00);
        wr(7'h00, 8'h20);
        rd_chk(7'h00, 8'h20, "reset bit held");
        wr(7'h00, 8'h00);
        wr(7'h22, 8'h0f);
        wr(7'h23, 8'h0f);
        rd_chk(7'h23, 8'h0f, "bias b");
        for (int i = 0; i < 9; i++)
        begin
            d = 8'($urandom);
            wr(RW_TAB[i], d);
            rd_chk(RW_TAB[i], d, "rw register");
            if (RW_TAB[i] == 7'h13) `CHK("skew", exp_skew(d), skew)
            if (RW_TAB[i] == 7'h14) `CHK("divider", exp_div(d), div)
        end
        wr(7'h21, 8'hff);
        rd_chk(7'h21, 8'h00, "read-only status");
        rd_chk(7'h55, 8'h00, "unmapped");
        wr(7'h00, 8'h04);
        rd_chk(7'h22, 8'h00, "cleared by mirrored reset");
        rd_chk(7'h00, 8'h04, "mirrored reset bit");
        wr(7'h00, 8'h42);
        dsis_host_model_i.lsb_first = 1'b1;
        rd_chk(7'h00, 8'h42, "lsb mode config");
        wr(7'h22, 8'ha5);
        wr(7'h00, 8'h00);
        dsis_host_model_i.lsb_first = 1'b0;
        rd_chk(7'h22, 8'ha5, "lsb written byte");
        wr(7'h26, 8'h02);
        wr(7'h10, 8'h03);
        repeat (LOCK_CYCLES + 8) @(posedge sys_clk_i);
        rd_chk(7'h21, 8'h00, "rx without loop");
        rd_chk(7'h2a, 8'h00, "loop without search");
        `CHK("data clock idle", 1'b0, odc)
        wr(7'h10, 8'h00);
        lock_try(7'h26, 7'h2a, 8'h01);
        @(negedge sys_clk_i);
        d[0] = odc;
        @(negedge sys_clk_i);
        `CHK("data clock toggle", ~d[0], odc)
        `CHK("loop irq", 1'b1, irq)
        wr(7'h13, 8'h72);
        `CHK("skew two", 4'h2, skew)
        lock_try(7'h10, 7'h21, 8'h09);
        wr(7'h14, 8'h40);
        `CHK("divider advanced", 2'h1, div)
        wr(7'h26, 8'h00);
        rd_chk(7'h21, 8'h00, "rx drops with loop");
        `CHK("irq off", 1'b0, irq)
        `CHK("data clock off", 1'b0, odc)
        @(posedge sys_clk_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        `CHK("skew after reset", 4'h0, skew)
        wr(7'h00, 8'h00);
        rd_chk(7'h22, 8'h00, "bias after reset");
        rd_chk(7'h10, 8'h00, "rx ctrl after reset");
        final_report();
    end
endmodule

bind dsis_top dsis_checker #(.LOCK_CYCLES(LOCK_CYCLES)) dsis_checker_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .spi_clk_i(spi_clk_i),
    .spi_cs_n_i(spi_cs_n_i), .spi_sdi_i(spi_sdi_i), .spi_sdo_o(spi_sdo_o),
    .spi_sdo_oe_o(spi_sdo_oe_o), .output_data_clock_o(output_data_clock_o),
    .controller_irq_o(controller_irq_o), .fine_input_delay_skew_o(fine_input_delay_skew_o),
    .clock_divider_phase_o(clock_divider_phase_o));
